// File: dv/gas_sensor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gas_sensor_chk #(
    parameter int SRST_CYCLES = 4,
    parameter int NVM_CYCLES  = 4
) (
    input wire logic       CLK,
    input wire logic       RESET_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       REG_RVALID,
    input wire logic       CONV_ACTIVE,
    input wire logic       BUSY_PIN,
    input wire logic       ALARM_PIN,
    input wire logic       MEAS_ENABLE,
    input wire logic       ZERO_ADJ_REQ,
    input wire logic       AIR_ADJ_REQ,
    input wire logic       PULSE_RANGE_SELECT,
    input wire logic [7:0] PRESSURE_OUT
);
    localparam int NVM_LIM  = NVM_CYCLES + 2;
    localparam int SRST_LIM = SRST_CYCLES + 2;
    // Writes are dropped only during a reset or persistent write; checks use writes with busy and conversion low
    logic idle_wr;
    assign idle_wr = REG_WR && !BUSY_PIN && !CONV_ACTIVE;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_read_answer: assert property (REG_RD |=> REG_RVALID) else $error("read left unanswered");
    a_rvalid_pulse: assert property (!REG_RD |=> !REG_RVALID) else $error("stray read valid");
    a_reserved_zero: assert property (REG_RD && REG_ADDR inside {8'h05, 8'h06, 8'h07, 8'h08, 8'h0B, 8'h11}
        |=> REG_RDATA == 8'h00) else $error("reserved read not zero");
    a_status_pins: assert property (REG_RD && REG_ADDR == 8'h02 |=> REG_RDATA[7] == $past(BUSY_PIN)
        && REG_RDATA[6] == $past(ALARM_PIN)) else $error("status and pins differ");
    a_conc_top_bit: assert property (REG_RD && REG_ADDR == 8'h04 |=> !REG_RDATA[7]) else $error("high byte bit7 set");
    a_nvm_busy: assert property (idle_wr && REG_ADDR == 8'h0C |=> BUSY_PIN[*2] ##[0:NVM_LIM] !BUSY_PIN)
        else $error("persistent write busy wrong");
    a_srst_busy: assert property (idle_wr && REG_ADDR == 8'h00 && REG_WDATA[0] |=> BUSY_PIN[*2] ##[0:SRST_LIM] !BUSY_PIN)
        else $error("soft reset busy wrong");
    a_conv_busy: assert property (CONV_ACTIVE |=> BUSY_PIN) else $error("busy low in conversion");
    a_zero_pulse: assert property (idle_wr && REG_ADDR == 8'h0E && REG_WDATA[1] |=> ZERO_ADJ_REQ ##1 !ZERO_ADJ_REQ)
        else $error("zero adjust pulse wrong");
    a_air_pulse: assert property (idle_wr && REG_ADDR == 8'h0E && REG_WDATA[0] |=> AIR_ADJ_REQ ##1 !AIR_ADJ_REQ)
        else $error("ambient adjust pulse wrong");
    a_mode_off: assert property (idle_wr && REG_ADDR == 8'h01 && REG_WDATA == 8'h00 |-> ##[1:2] !MEAS_ENABLE)
        else $error("power down not taken");
    a_cfg_range: assert property (idle_wr && REG_ADDR == 8'h0F |=> PULSE_RANGE_SELECT == $past(REG_WDATA[3]))
        else $error("range select wrong");
    a_press_out: assert property (idle_wr && REG_ADDR == 8'h09 |=> PRESSURE_OUT == $past(REG_WDATA))
        else $error("pressure output wrong");
    c_nvm: cover property (idle_wr && REG_ADDR == 8'h0C);
    c_alarm: cover property ($rose(ALARM_PIN));
    c_zero: cover property (ZERO_ADJ_REQ);
    c_off: cover property ($fell(MEAS_ENABLE));
endmodule
bind gas_sensor_register_map gas_sensor_chk #(.SRST_CYCLES(SRST_CYCLES), .NVM_CYCLES(NVM_CYCLES)) u_chk (
    .CLK, .RESET_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .REG_RVALID, .CONV_ACTIVE,
    .BUSY_PIN, .ALARM_PIN, .MEAS_ENABLE, .ZERO_ADJ_REQ, .AIR_ADJ_REQ, .PULSE_RANGE_SELECT, .PRESSURE_OUT
);
`default_nettype wire

// File: dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid,
    output logic      [7:0] addr,
    output logic            wr,
    output logic      [7:0] wdata,
    output logic            rd
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Released lines show the inverse so stale values never match by luck
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(negedge clk);
        d = rdata;
        ok = rvalid;
    endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        mv = 1'b0;
    logic [14:0] mc = 15'h0000;
    logic        conv = 1'b0;
    logic        fault = 1'b0;
    logic        strap = 1'b1;
    logic        isel = 1'b0;
    logic [7:0]  addr, wdata, rdata, press, alt;
    logic        wr, rd, rvalid, busy, alarm, men, zreq, areq, pwe, prs, pce;
    int          failures = 0;
    int          compares = 0;
    always #5 clk = ~clk;
    gas_sensor_register_map #(.SRST_CYCLES(8), .NVM_CYCLES(6)) dut (
        .CLK(clk), .RESET_N(reset_n), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .MEAS_VALID(mv), .MEAS_CONC(mc), .CONV_ACTIVE(conv),
        .FAULT_IN(fault), .ADDRESS_STRAP_PIN(strap), .INTERFACE_SELECT_PIN(isel), .BUSY_PIN(busy),
        .ALARM_PIN(alarm), .MEAS_ENABLE(men), .ZERO_ADJ_REQ(zreq), .AIR_ADJ_REQ(areq),
        .PULSE_OUTPUT_ENABLE(pwe), .PULSE_RANGE_SELECT(prs), .PRESSURE_CORRECTION_ENABLE(pce),
        .PRESSURE_OUT(press), .ALTITUDE_OUT(alt));
    host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd));
    task automatic conclude;
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host.rd_byte(a, d, ok);
        chk({ok, 7'h00, d}, {1'b1, 7'h00, e});
    endtask
    // Host holds off until busy has fallen before touching results
    task automatic idle;
        int n;
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n >= 200), 16'h0000);
    endtask
    task automatic meas(input logic [14:0] v);
        @(posedge clk);
        mv <= 1'b1;
        mc <= v;
        @(posedge clk);
        mv <= 1'b0;
        mc <= ~v;
        repeat (4) @(posedge clk);
    endtask
    task automatic conc(input logic [14:0] e);
        rdchk(8'h03, e[7:0]);
        rdchk(8'h04, {1'b0, e[14:8]});
    endtask
    task automatic t_reset_vals;
        logic [7:0] ra [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h12};
        logic [7:0] re [13] = '{8'h00, 8'h06, 8'h02, 8'h00, 8'h00, 8'hD5, 8'h00, 8'h64, 8'h5C, 8'h00, 8'h01, 8'h00, 8'h28};
        foreach (ra[i]) rdchk(ra[i], re[i]);
    endtask
    task automatic t_reserved;
        logic [7:0] rs [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h0B, 8'h11};
        foreach (rs[i]) begin
            host.wr_byte(rs[i], 8'hA5);
            rdchk(rs[i], 8'h00);
        end
        host.wr_byte(8'h02, 8'hFF);
        rdchk(8'h02, 8'h02);
        @(posedge clk);
        strap <= 1'b0;
        isel <= 1'b1;
        repeat (5) @(posedge clk);
        rdchk(8'h02, 8'h01);
        @(posedge clk);
        strap <= 1'b1;
        isel <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic t_alarm;
        meas(15'd1001);
        chk(alarm, 1'b1);
        rdchk(8'h02, 8'h42);
        conc(15'd1001);
        meas(15'd950);
        chk(alarm, 1'b1);
        meas(15'd919);
        chk(alarm, 1'b0);
        meas(15'd1000);
        chk(alarm, 1'b0);
        meas(15'd12000);
        conc(15'd10000);
        chk(alarm, 1'b1);
    endtask
    task automatic t_nvm_mode;
        host.wr_byte(8'h0C, 8'h32);
        @(negedge clk);
        chk(busy, 1'b1);
        host.wr_byte(8'h0D, 8'h10);
        idle;
        rdchk(8'h0D, 8'h5C);
        rdchk(8'h0C, 8'h32);
        host.wr_byte(8'h0C, 8'h64);
        idle;
        host.wr_byte(8'h01, 8'h00);
        idle;
        chk(men, 1'b0);
        meas(15'd500);
        conc(15'd10000);
        host.wr_byte(8'h01, 8'h06);
        idle;
        chk(men, 1'b1);
        rdchk(8'h01, 8'h06);
    endtask
    task automatic t_adjust_cfg;
        host.wr_byte(8'h0E, 8'h02);
        @(negedge clk);
        chk(zreq, 1'b1);
        conc(15'd0);
        host.wr_byte(8'h12, 8'h32);
        idle;
        host.wr_byte(8'h0E, 8'h01);
        @(negedge clk);
        chk(areq, 1'b1);
        conc(15'd500);
        rdchk(8'h0E, 8'h00);
        host.wr_byte(8'h0F, 8'hFF);
        idle;
        rdchk(8'h0F, 8'h0D);
        chk({prs, pce, pwe}, 3'b111);
        host.wr_byte(8'h09, 8'h12);
        idle;
        chk(press, 8'h12);
        host.wr_byte(8'h0A, 8'h34);
        idle;
        chk(alt, 8'h34);
    endtask
    task automatic t_soft_reset;
        @(posedge clk);
        fault <= 1'b1;
        @(posedge clk);
        fault <= 1'b0;
        repeat (2) @(posedge clk);
        rdchk(8'h10, 8'h01);
        host.wr_byte(8'h00, 8'h01);
        rdchk(8'h00, 8'h01);
        idle;
        rdchk(8'h00, 8'h00);
        rdchk(8'h10, 8'h00);
        conc(15'd0);
        rdchk(8'h0F, 8'h0D);
        rdchk(8'h09, 8'h12);
        @(posedge clk);
        conv <= 1'b1;
        repeat (2) @(posedge clk);
        rdchk(8'h02, 8'h82);
        @(posedge clk);
        conv <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_reset_vals;
        t_reserved;
        t_alarm;
        t_nvm_mode;
        t_adjust_cfg;
        t_soft_reset;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude;
    end
endmodule
`default_nettype wire

// File: include/gas_sensor_pkg.sv
package gas_sensor_pkg;

    // Register offsets, one byte per address
    localparam logic [7:0] ADDR_SOFT_RESET    = 8'h00;
    localparam logic [7:0] ADDR_OPER_MODE     = 8'h01;
    localparam logic [7:0] ADDR_STATUS_ONE    = 8'h02;
    localparam logic [7:0] ADDR_CONC_LOW      = 8'h03;
    localparam logic [7:0] ADDR_CONC_HIGH     = 8'h04;
    localparam logic [7:0] ADDR_PRESSURE      = 8'h09;
    localparam logic [7:0] ADDR_ALTITUDE      = 8'h0A;
    localparam logic [7:0] ADDR_ALARM_UPPER   = 8'h0C;
    localparam logic [7:0] ADDR_ALARM_LOWER   = 8'h0D;
    localparam logic [7:0] ADDR_USER_ADJUST   = 8'h0E;
    localparam logic [7:0] ADDR_FEATURE_CFG   = 8'h0F;
    localparam logic [7:0] ADDR_SELF_DIAG     = 8'h10;
    localparam logic [7:0] ADDR_ADJUST_TARGET = 8'h12;

    // Field positions
    localparam int RESET_TRIGGER_BIT  = 0;
    localparam int STATUS_BUSY_BIT    = 7;
    localparam int STATUS_ALARM_BIT   = 6;
    localparam int STATUS_ADDR_BIT    = 1;
    localparam int STATUS_IFSEL_BIT   = 0;
    localparam int ADJUST_ZERO_BIT    = 1;
    localparam int ADJUST_AIR_BIT     = 0;
    localparam int CFG_PULSE_RANGE    = 3;
    localparam int CFG_PRESS_CORR     = 2;
    localparam int CFG_PULSE_OUT      = 0;
    localparam int DIAG_FAULT_BIT     = 0;
    localparam int MODE_W             = 3;
    localparam int CONC_W             = 15;

    // Mode codes
    localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
    localparam logic [2:0] MODE_CONTINUOUS = 3'h6;

    // Reset and shipment values
    localparam logic [2:0]  RESET_OPER_MODE  = MODE_CONTINUOUS;
    localparam logic [7:0]  RESET_PRESSURE   = 8'hD5;
    localparam logic [7:0]  RESET_ALTITUDE   = 8'h00;
    localparam logic [7:0]  RESET_ALARM_UP   = 8'h64;
    localparam logic [7:0]  RESET_ALARM_LO   = 8'h5C;
    localparam logic [7:0]  RESET_FEATURE    = 8'h01;
    localparam logic [7:0]  RESET_ADJ_TARGET = 8'h28;
    localparam logic [1:0]  RESET_STRAPS     = 2'h2;
    localparam logic [14:0] CONC_MAX         = 15'h2710;
    localparam logic [14:0] THRESHOLD_SCALE  = 15'h000A;

    // Timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int SOFT_RESET_TIME_NS = 1000;
    localparam int NVM_WRITE_TIME_NS  = 5000;
    localparam int SOFT_RESET_CYCLES  = (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NVM_WRITE_CYCLES   = (NVM_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_W            = 16;

    typedef enum logic [1:0] {
        SEQ_RUN  = 2'b00,
        SEQ_SRST = 2'b01,
        SEQ_NVM  = 2'b11
    } seq_state_t;

endpackage

// File: verilog/gas_sensor_register_map.sv
// Contract
// - Every address holds one byte, read or written whole.
// - Persistent registers survive soft reset; volatile ones return to initial values.
// - Writing one to address 00 bit 0 resets; bit clears when done.
// - Mode field: 000 is power-down, 110 is continuous measurement.
// - Status is read-only; busy bit high whenever results are not readable.
// - Busy pin always equals the busy status bit.
// - Alarm sets above ten times upper byte, clears below ten times lower.
// - Alarm pin mirrors the alarm status bit.
// - Status bits 1 and 0 show address strap and interface select pins.
// - Unconnected address strap reads as high.
// - Concentration is 15 bits, low byte at 03, high at 04, bit 7 zero.
// - Concentration little-endian, range zero to ten thousand ppm.
// - Address 0E volatile command: bit 1 zero adjust, bit 0 ambient adjust.
// - Zero adjust forces zero ppm; ambient adjust forces stored target.
// - Address 12 persistent adjust target, default meaning 400 ppm.
// - Address 0F: pulse range bit 3, pressure correction bit 2, pulse enable bit 0.
// - Feature register untouched by soft reset.
// - Address 09 persistent pressure byte for correction.
// - Pressure byte means hectopascals minus eight hundred.
// - Address 0A persistent altitude byte for correction.
// - Addresses 0C and 0D persistent alarm thresholds, compared times ten.
`timescale 1ns/1ps
`default_nettype none

module gas_sensor_register_map #(
    parameter int SRST_CYCLES = gas_sensor_pkg::SOFT_RESET_CYCLES,
    parameter int NVM_CYCLES  = gas_sensor_pkg::NVM_WRITE_CYCLES
) (
    input  wire logic                              CLK,
    input  wire logic                              RESET_N,
    input  wire logic [7:0]                        REG_ADDR,
    input  wire logic                              REG_WR,
    input  wire logic [7:0]                        REG_WDATA,
    input  wire logic                              REG_RD,
    output logic      [7:0]                        REG_RDATA,
    output logic                                   REG_RVALID,
    input  wire logic                              MEAS_VALID,
    input  wire logic [gas_sensor_pkg::CONC_W-1:0] MEAS_CONC,
    input  wire logic                              CONV_ACTIVE,
    input  wire logic                              FAULT_IN,
    input  wire logic                              ADDRESS_STRAP_PIN,
    input  wire logic                              INTERFACE_SELECT_PIN,
    output logic                                   BUSY_PIN,
    output logic                                   ALARM_PIN,
    output logic                                   MEAS_ENABLE,
    output logic                                   ZERO_ADJ_REQ,
    output logic                                   AIR_ADJ_REQ,
    output logic                                   PULSE_OUTPUT_ENABLE,
    output logic                                   PULSE_RANGE_SELECT,
    output logic                                   PRESSURE_CORRECTION_ENABLE,
    output logic      [7:0]                        PRESSURE_OUT,
    output logic      [7:0]                        ALTITUDE_OUT
);

    function automatic logic is_persistent(input logic [7:0] a);
        case (a)
            gas_sensor_pkg::ADDR_OPER_MODE,
            gas_sensor_pkg::ADDR_PRESSURE,
            gas_sensor_pkg::ADDR_ALTITUDE,
            gas_sensor_pkg::ADDR_ALARM_UPPER,
            gas_sensor_pkg::ADDR_ALARM_LOWER,
            gas_sensor_pkg::ADDR_FEATURE_CFG,
            gas_sensor_pkg::ADDR_ADJUST_TARGET: is_persistent = 1'b1;
            default:                            is_persistent = 1'b0;
        endcase
    endfunction

    function automatic logic [14:0] times_ten(input logic [7:0] v);
        times_ten = 15'({7'h00, v} * gas_sensor_pkg::THRESHOLD_SCALE);
    endfunction

    gas_sensor_pkg::seq_state_t seq_reg;
    logic [gas_sensor_pkg::DELAY_W-1:0] delay_reg;
    logic [gas_sensor_pkg::MODE_W-1:0]  oper_mode_reg;
    logic [7:0]                         pressure_reg;
    logic [7:0]                         altitude_reg;
    logic [7:0]                         alarm_high_setting;
    logic [7:0]                         alarm_low_setting;
    logic [7:0]                         feature_config_reg;
    logic [7:0]                         adjust_target_reg;
    logic [gas_sensor_pkg::CONC_W-1:0]  conc_reg;
    logic                               alarm_reg;
    logic                               busy_reg;
    logic                               fault_reg;
    logic                               zero_req_reg;
    logic                               air_req_reg;
    logic                               meas_en_reg;
    logic [7:0]                         rdata_reg;
    logic                               rvalid_reg;
    logic [1:0]                         strap_state_reg;
    logic [1:0]                         strap_raw;
    logic                               accept_wr;
    logic                               srst_wr;
    logic                               nvm_wr;
    logic                               adjust_wr;
    logic                               in_srst;
    logic                               status_busy;
    logic [7:0]                         status_one_reg;

    // Writes are refused while a reset or persistent write is in progress
    assign accept_wr = REG_WR && (seq_reg == gas_sensor_pkg::SEQ_RUN);
    assign srst_wr   = accept_wr && (REG_ADDR == gas_sensor_pkg::ADDR_SOFT_RESET)
                       && REG_WDATA[gas_sensor_pkg::RESET_TRIGGER_BIT];
    assign nvm_wr    = accept_wr && is_persistent(REG_ADDR);
    assign adjust_wr = accept_wr && (REG_ADDR == gas_sensor_pkg::ADDR_USER_ADJUST);
    assign in_srst   = (seq_reg == gas_sensor_pkg::SEQ_SRST);
    assign strap_raw = {ADDRESS_STRAP_PIN, INTERFACE_SELECT_PIN};

    // Straps: three flops, a change counts once the last two agree
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_strap
            logic [2:0] sync_reg;
            always_ff @(posedge CLK) begin
                if (!RESET_N) begin
                    sync_reg <= {3{gas_sensor_pkg::RESET_STRAPS[gi]}};
                end else begin
                    sync_reg <= {sync_reg[1:0], strap_raw[gi]};
                end
            end
            always_ff @(posedge CLK) begin
                if (!RESET_N) begin
                    strap_state_reg[gi] <= gas_sensor_pkg::RESET_STRAPS[gi];
                end else if (sync_reg[1] == sync_reg[2]) begin
                    strap_state_reg[gi] <= sync_reg[2];
                end
            end
        end
    endgenerate

    // Sequencer for soft reset and persistent write time
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            seq_reg   <= gas_sensor_pkg::SEQ_RUN;
            delay_reg <= '0;
        end else begin
            case (seq_reg)
                gas_sensor_pkg::SEQ_RUN: begin
                    if (srst_wr) begin
                        seq_reg   <= gas_sensor_pkg::SEQ_SRST;
                        delay_reg <= gas_sensor_pkg::DELAY_W'(SRST_CYCLES - 1);
                    end else if (nvm_wr) begin
                        seq_reg   <= gas_sensor_pkg::SEQ_NVM;
                        delay_reg <= gas_sensor_pkg::DELAY_W'(NVM_CYCLES - 1);
                    end
                end
                gas_sensor_pkg::SEQ_SRST,
                gas_sensor_pkg::SEQ_NVM: begin
                    if (delay_reg == '0) begin
                        seq_reg <= gas_sensor_pkg::SEQ_RUN;
                    end else begin
                        delay_reg <= delay_reg - 1'b1;
                    end
                end
                default: begin
                    seq_reg   <= gas_sensor_pkg::SEQ_RUN;
                    delay_reg <= '0;
                end
            endcase
        end
    end

    // Persistent store: loaded at power-up, never touched by soft reset
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            oper_mode_reg      <= gas_sensor_pkg::RESET_OPER_MODE;
            pressure_reg       <= gas_sensor_pkg::RESET_PRESSURE;
            altitude_reg       <= gas_sensor_pkg::RESET_ALTITUDE;
            alarm_high_setting <= gas_sensor_pkg::RESET_ALARM_UP;
            alarm_low_setting  <= gas_sensor_pkg::RESET_ALARM_LO;
            feature_config_reg <= gas_sensor_pkg::RESET_FEATURE;
            adjust_target_reg  <= gas_sensor_pkg::RESET_ADJ_TARGET;
        end else if (nvm_wr) begin
            case (REG_ADDR)
                gas_sensor_pkg::ADDR_OPER_MODE:     oper_mode_reg      <= REG_WDATA[2:0];
                gas_sensor_pkg::ADDR_PRESSURE:      pressure_reg       <= REG_WDATA;
                gas_sensor_pkg::ADDR_ALTITUDE:      altitude_reg       <= REG_WDATA;
                gas_sensor_pkg::ADDR_ALARM_UPPER:   alarm_high_setting <= REG_WDATA;
                gas_sensor_pkg::ADDR_ALARM_LOWER:   alarm_low_setting  <= REG_WDATA;
                gas_sensor_pkg::ADDR_FEATURE_CFG:   feature_config_reg <= REG_WDATA & 8'h0D;
                gas_sensor_pkg::ADDR_ADJUST_TARGET: adjust_target_reg  <= REG_WDATA;
                default: begin
                end
            endcase
        end
    end

    // Adjust command is write-only; it leaves one-cycle requests behind
    always_ff @(posedge CLK) begin
        if (!RESET_N || in_srst) begin
            zero_req_reg <= 1'b0;
            air_req_reg  <= 1'b0;
        end else begin
            zero_req_reg <= adjust_wr && REG_WDATA[gas_sensor_pkg::ADJUST_ZERO_BIT];
            air_req_reg  <= adjust_wr && REG_WDATA[gas_sensor_pkg::ADJUST_AIR_BIT];
        end
    end

    // Concentration result, clamped to the legal range
    always_ff @(posedge CLK) begin
        if (!RESET_N || in_srst) begin
            conc_reg <= '0;
        end else if (adjust_wr && REG_WDATA[gas_sensor_pkg::ADJUST_ZERO_BIT]) begin
            conc_reg <= '0;
        end else if (adjust_wr && REG_WDATA[gas_sensor_pkg::ADJUST_AIR_BIT]) begin
            conc_reg <= times_ten(adjust_target_reg);
        end else if (MEAS_VALID && oper_mode_reg == gas_sensor_pkg::MODE_CONTINUOUS) begin
            if (MEAS_CONC > gas_sensor_pkg::CONC_MAX) begin
                conc_reg <= gas_sensor_pkg::CONC_MAX;
            end else begin
                conc_reg <= MEAS_CONC;
            end
        end
    end

    // Hysteresis alarm; equal thresholds give no chatter since both are strict
    always_ff @(posedge CLK) begin
        if (!RESET_N || in_srst) begin
            alarm_reg <= 1'b0;
        end else if (conc_reg > times_ten(alarm_high_setting)) begin
            alarm_reg <= 1'b1;
        end else if (conc_reg < times_ten(alarm_low_setting)) begin
            alarm_reg <= 1'b0;
        end
    end

    // Fault is sticky until soft reset; a new fault wins over the clear
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            fault_reg <= 1'b0;
        end else if (FAULT_IN) begin
            fault_reg <= 1'b1;
        end else if (in_srst) begin
            fault_reg <= 1'b0;
        end
    end

    // Busy covers conversion, reset, persistent write and the write cycle itself
    assign status_busy = CONV_ACTIVE || srst_wr || nvm_wr
                         || (seq_reg != gas_sensor_pkg::SEQ_RUN);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= status_busy;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N || in_srst) begin
            meas_en_reg <= 1'b0;
        end else begin
            meas_en_reg <= (oper_mode_reg == gas_sensor_pkg::MODE_CONTINUOUS);
        end
    end

    always_comb begin
        status_one_reg = 8'h00;
        status_one_reg[gas_sensor_pkg::STATUS_BUSY_BIT]  = busy_reg;
        status_one_reg[gas_sensor_pkg::STATUS_ALARM_BIT] = alarm_reg;
        status_one_reg[gas_sensor_pkg::STATUS_ADDR_BIT]  = strap_state_reg[1];
        status_one_reg[gas_sensor_pkg::STATUS_IFSEL_BIT] = strap_state_reg[0];
    end

    // Read port; reserved and unlisted addresses answer zero
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= REG_RD;
            if (REG_RD) begin
                case (REG_ADDR)
                    gas_sensor_pkg::ADDR_SOFT_RESET:    rdata_reg <= {7'h00, in_srst};
                    gas_sensor_pkg::ADDR_OPER_MODE:     rdata_reg <= {5'h00, oper_mode_reg};
                    gas_sensor_pkg::ADDR_STATUS_ONE:    rdata_reg <= status_one_reg;
                    gas_sensor_pkg::ADDR_CONC_LOW:      rdata_reg <= conc_reg[7:0];
                    gas_sensor_pkg::ADDR_CONC_HIGH:     rdata_reg <= {1'b0, conc_reg[14:8]};
                    gas_sensor_pkg::ADDR_PRESSURE:      rdata_reg <= pressure_reg;
                    gas_sensor_pkg::ADDR_ALTITUDE:      rdata_reg <= altitude_reg;
                    gas_sensor_pkg::ADDR_ALARM_UPPER:   rdata_reg <= alarm_high_setting;
                    gas_sensor_pkg::ADDR_ALARM_LOWER:   rdata_reg <= alarm_low_setting;
                    gas_sensor_pkg::ADDR_FEATURE_CFG:   rdata_reg <= feature_config_reg;
                    gas_sensor_pkg::ADDR_SELF_DIAG:     rdata_reg <= {7'h00, fault_reg};
                    gas_sensor_pkg::ADDR_ADJUST_TARGET: rdata_reg <= adjust_target_reg;
                    default:                            rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    assign REG_RDATA                  = rdata_reg;
    assign REG_RVALID                 = rvalid_reg;
    assign BUSY_PIN                   = busy_reg;
    assign ALARM_PIN                  = alarm_reg;
    assign MEAS_ENABLE                = meas_en_reg;
    assign ZERO_ADJ_REQ               = zero_req_reg;
    assign AIR_ADJ_REQ                = air_req_reg;
    assign PULSE_OUTPUT_ENABLE        = feature_config_reg[gas_sensor_pkg::CFG_PULSE_OUT];
    assign PULSE_RANGE_SELECT         = feature_config_reg[gas_sensor_pkg::CFG_PULSE_RANGE];
    assign PRESSURE_CORRECTION_ENABLE = feature_config_reg[gas_sensor_pkg::CFG_PRESS_CORR];
    assign PRESSURE_OUT               = pressure_reg;
    assign ALTITUDE_OUT               = altitude_reg;

endmodule

`default_nettype wire
